// ### hdl/pms_pkg.sv
package pms_pkg;

  // Register bus geometry
  localparam int          DW            = 16;
  localparam int          AW            = 4;

  // Register word offsets
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_BW_NORM  = 4'h1;
  localparam logic [3:0]  ADDR_BW_FAST  = 4'h2;
  localparam logic [3:0]  ADDR_HOLD     = 4'h3;
  localparam logic [3:0]  ADDR_TRIM     = 4'h4;
  localparam logic [3:0]  ADDR_PREDIV   = 4'h5;
  localparam logic [3:0]  ADDR_STATUS   = 4'h6;

  // Words copied out of the nonvolatile store (offsets 0 to 5)
  localparam logic [2:0]  NV_WORDS      = 3'h6;

  // Control word bits
  localparam int          CTRL_FAST_BIT = 0;
  localparam int          CTRL_EXT_BIT  = 1;
  localparam int          CTRL_SOFT_BIT = 2;
  localparam int          CTRL_HARD_BIT = 3;

  // Holdover word fields
  localparam int          HOLD_WIN_LSB  = 0;
  localparam int          HOLD_DLY_LSB  = 4;

  // Status word fields
  localparam int          ST_MODE_LSB   = 0;
  localparam int          ST_LOL_BIT    = 3;
  localparam int          ST_HVAL_BIT   = 4;
  localparam int          ST_VALID_LSB  = 8;

  // Bandwidth codes in units of 0.1 Hz
  localparam logic [15:0] BW_MIN        = 16'h0001;
  localparam logic [15:0] BW_FAST_MIN   = 16'h03e8;
  localparam logic [15:0] BW_MAX        = 16'h9c40;

  // Trim in units of 0.01 ppm, limit 200 ppm
  localparam logic signed [15:0] TRIM_MAX = 16'sh4e20;

  // Largest averaging window, as a power of two
  localparam logic [2:0]  WIN_LOG_MAX   = 3'h4;

  // Reset values
  localparam logic [15:0] RST_BW_NORM   = 16'h03e8;
  localparam logic [15:0] RST_BW_FAST   = 16'h2710;
  localparam logic [2:0]  RST_WIN_LOG   = 3'h4;
  localparam logic [3:0]  RST_DLY       = 4'h1;
  localparam logic [7:0]  RST_PREDIV    = 8'h01;

  // Inputs and frequency history
  localparam int          NIN           = 4;
  localparam int          HIST_DEPTH    = 16;
  localparam int          HIST_SPAN_S   = 120;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          HIST_SAMPLE_CYC = HIST_SPAN_S * CLK_HZ / HIST_DEPTH;

  // Controller modes
  typedef enum logic [2:0] {
    PMS_INIT,
    PMS_FREERUN,
    PMS_ACQ,
    PMS_LOCKED,
    PMS_HOLD
  } pms_mode_t;

  // Loop and reference configuration
  typedef struct packed {
    logic               fast_en;
    logic               ext_ref;
    logic [15:0]        bw_norm;
    logic [15:0]        bw_fast;
    logic [2:0]         win_log;
    logic [3:0]         delay;
    logic signed [15:0] trim;
    logic [7:0]         prediv;
  } pms_cfg_t;

  localparam pms_cfg_t CFG_RST = '{
    fast_en: 1'b0, ext_ref: 1'b0, bw_norm: RST_BW_NORM, bw_fast: RST_BW_FAST,
    win_log: RST_WIN_LOG, delay: RST_DLY, trim: 16'sh0000, prediv: RST_PREDIV};

endpackage : pms_pkg

// ### hdl/pms_pll_mode_sequencer.sv
// Overview of operation
// R01 - Normal bandwidth register, 0.1 Hz to 4 kHz
// R02 - Fast-lock bandwidth 100 Hz-4 kHz during acquisition
// R03 - Return to normal bandwidth once locked
// R04 - After init, exactly one of four modes
// R05 - Power-up copies configuration from nonvolatile store
// R06 - Host access only after initialization
// R07 - Output clocks off until initialization ends
// R08 - Hard reset reloads store, resets everything
// R09 - Hard reset by pin or register bit
// R10 - Soft reset applies configuration, no reload
// R11 - Init complete enters free-run unaided
// R12 - Any valid input starts lock acquisition
// R13 - Outputs keep running during acquisition
// R14 - Lock loss on pin and status bit
// R15 - Holdover when no valid input remains; code goes to free-run instead when acquisition ends with no history stored
// R16 - Record 120 seconds of frequency history
// R17 - Average programmable window after programmable delay
// R18 - Holdover steers to averaged frequency
// R19 - Valid input in holdover reacquires lock
// R20 - Crystal or external reference, caps off
// R21 - Reference trim within 200 ppm
// R22 - Reference pre-divider for fast references
// R23 - Lock loss asserted while pulling in
// R24 - Other valid input: reacquire, not holdover
module pms_pll_mode_sequencer #(
  parameter int HIST_SAMPLE_CYC = pms_pkg::HIST_SAMPLE_CYC  // Cycles between history samples
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rst_pin_n_i,
  input  wire logic [3:0]  input_valid_i,
  input  wire logic        lock_detect_i,
  input  wire logic [15:0] freq_word_i,
  output logic             nonvolatile_store_rd_o,
  output logic [2:0]       nonvolatile_store_addr_o,
  input  wire logic [15:0] nonvolatile_store_data_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rd_data_o,
  output logic             host_ready_o,
  output logic             out_en_o,
  output logic             lock_loss_indicator_o,
  output logic [2:0]       mode_o,
  output logic [1:0]       selected_input_o,
  output logic [15:0]      active_bw_o,
  output logic             fastlock_active_o,
  output logic [15:0]      freq_steer_o,
  output logic             ext_ref_clock_sel_o,
  output logic             load_cap_en_o,
  output logic [15:0]      trim_o,
  output logic [7:0]       prediv_o
);

  // Whole module state
  typedef struct packed {
    pms_pkg::pms_mode_t mode;       // Controller mode
    pms_pkg::pms_cfg_t  act;        // Configuration in effect
    pms_pkg::pms_cfg_t  shd;        // Configuration as written
    logic [1:0]         sel;        // Selected input
    logic               nv_rd;      // Store read strobe
    logic [2:0]         nv_addr;    // Store word index
    logic               nv_pend;    // Store data due this cycle
    logic               s1;         // Pin synchroniser stages
    logic               s2;
    logic               s3;
    logic               pin_rst;    // Filtered reset pin level
    logic [15:0][15:0]  hist;       // Frequency history ring
    logic [3:0]         wp;         // Next history slot
    logic [4:0]         hcnt;       // Stored history entries
    logic [31:0]        tick;       // Sample interval counter
    logic               avg_busy;   // Averaging in progress
    logic [4:0]         avg_i;      // Entries summed so far
    logic [19:0]        acc;        // Running sum
    logic [15:0]        hold_freq;  // Averaged holdover frequency
    logic               hold_valid; // Holdover value ready
    logic               out_en;     // Output clocks enabled
    logic               lock_loss_indicator;        // Lock lost
    logic               fast_act;   // Fast bandwidth in use
    logic [15:0]        active_bw;  // Bandwidth in use
    logic [15:0]        freq_steer; // Frequency steering word
    logic               load_cap;   // Crystal load capacitors
    logic [15:0]        rd_data;    // Read answer
  } pms_state_t;

  pms_state_t  s;         // Registered state
  pms_state_t  n;         // Next state
  logic        hard_req;  // Hard reset requested this cycle
  logic        bus_ok;    // Host interface usable
  logic        any_v;     // Some input is valid
  logic        sel_v;     // Selected input is valid
  logic [1:0]  first_v;   // Lowest numbered valid input
  logic [3:0]  idx;       // History slot being averaged
  logic [4:0]  win;       // Window length in entries
  logic [19:0] acc_new;   // Sum including current slot
  logic [15:0] st;        // Status word

  // Reset image of the state
  function automatic pms_state_t pms_reset_f();
    pms_state_t r;
    r         = '0;
    r.mode    = pms_pkg::PMS_INIT;
    r.act     = pms_pkg::CFG_RST;
    r.shd     = pms_pkg::CFG_RST;
    r.s1      = 1'b1;
    r.s2      = 1'b1;
    r.s3      = 1'b1;
    r.lock_loss_indicator     = 1'b1;
    r.load_cap = 1'b1;
    return r;
  endfunction : pms_reset_f

  // Limit an unsigned code to a range
  function automatic logic [15:0] pms_clamp_f(input logic [15:0] d, input logic [15:0] lo,
                                              input logic [15:0] hi);
    if (d < lo) begin
      return lo;
    end
    if (d > hi) begin
      return hi;
    end
    return d;
  endfunction : pms_clamp_f

  // Write one configuration word, limiting each field to its legal range
  function automatic pms_pkg::pms_cfg_t pms_cfg_wr_f(input pms_pkg::pms_cfg_t c, input logic [3:0] a,
                                                     input logic [15:0] d);
    pms_pkg::pms_cfg_t r;
    r = c;
    case (a)
      pms_pkg::ADDR_CTRL: begin
        r.fast_en = d[pms_pkg::CTRL_FAST_BIT];
        r.ext_ref = d[pms_pkg::CTRL_EXT_BIT];
      end
      pms_pkg::ADDR_BW_NORM: begin
        r.bw_norm = pms_clamp_f(d, pms_pkg::BW_MIN, pms_pkg::BW_MAX);  // R01
      end
      pms_pkg::ADDR_BW_FAST: begin
        r.bw_fast = pms_clamp_f(d, pms_pkg::BW_FAST_MIN, pms_pkg::BW_MAX);  // R02
      end
      pms_pkg::ADDR_HOLD: begin
        r.win_log = (d[pms_pkg::HOLD_WIN_LSB +: 3] > pms_pkg::WIN_LOG_MAX) ? pms_pkg::WIN_LOG_MAX
                                                                            : d[pms_pkg::HOLD_WIN_LSB +: 3];
        r.delay   = d[pms_pkg::HOLD_DLY_LSB +: 4];  // R17
      end
      pms_pkg::ADDR_TRIM: begin
        // R21
        if ($signed(d) > pms_pkg::TRIM_MAX) begin
          r.trim = pms_pkg::TRIM_MAX;
        end else if ($signed(d) < -pms_pkg::TRIM_MAX) begin
          r.trim = -pms_pkg::TRIM_MAX;
        end else begin
          r.trim = $signed(d);
        end
      end
      pms_pkg::ADDR_PREDIV: begin
        r.prediv = (d[7:0] == 8'h00) ? 8'h01 : d[7:0];  // R22
      end
      default: begin
      end
    endcase
    return r;
  endfunction : pms_cfg_wr_f

  // Next state computation
  always_comb begin
    n        = s;
    hard_req = s.pin_rst;  // R09
    bus_ok   = (s.mode != pms_pkg::PMS_INIT);  // R06
    any_v    = |input_valid_i;
    sel_v    = input_valid_i[s.sel];
    first_v  = 2'h0;
    idx      = 4'(s.wp - 4'h1 - s.act.delay - s.avg_i[3:0]);  // R17
    win      = 5'(5'h01 << s.act.win_log);
    acc_new  = s.acc + 20'(s.hist[idx]);
    st       = 16'h0000;
    // Lowest numbered valid input wins
    for (int i = pms_pkg::NIN - 1; i >= 0; i--) begin
      if (input_valid_i[i]) begin
        first_v = 2'(i);
      end
    end

    // Reset pin synchroniser, filtered once two stages agree
    n.s1 = rst_pin_n_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.pin_rst = ~s.s3;
    end

    // Host writes go to the written copy
    if (wr_i && bus_ok) begin  // R06
      n.shd = pms_cfg_wr_f(s.shd, addr_i, wdata_i);
      if (addr_i == pms_pkg::ADDR_CTRL) begin
        if (wdata_i[pms_pkg::CTRL_SOFT_BIT]) begin
          n.act = n.shd;  // R10
        end
        if (wdata_i[pms_pkg::CTRL_HARD_BIT]) begin
          hard_req = 1'b1;  // R09
        end
      end
    end

    // Status word
    st[pms_pkg::ST_MODE_LSB +: 3]  = s.mode;
    st[pms_pkg::ST_LOL_BIT]        = s.lock_loss_indicator;  // R14
    st[pms_pkg::ST_HVAL_BIT]       = s.hold_valid;
    st[pms_pkg::ST_VALID_LSB +: 4] = input_valid_i;

    // Read answer stands one cycle only
    n.rd_data = 16'h0000;
    if (rd_i && bus_ok) begin  // R06
      case (addr_i)
        pms_pkg::ADDR_CTRL: begin
          n.rd_data[pms_pkg::CTRL_FAST_BIT] = s.shd.fast_en;
          n.rd_data[pms_pkg::CTRL_EXT_BIT]  = s.shd.ext_ref;
        end
        pms_pkg::ADDR_BW_NORM: n.rd_data = s.shd.bw_norm;
        pms_pkg::ADDR_BW_FAST: n.rd_data = s.shd.bw_fast;
        pms_pkg::ADDR_HOLD: begin
          n.rd_data[pms_pkg::HOLD_WIN_LSB +: 3] = s.shd.win_log;
          n.rd_data[pms_pkg::HOLD_DLY_LSB +: 4] = s.shd.delay;
        end
        pms_pkg::ADDR_TRIM:   n.rd_data = s.shd.trim;
        pms_pkg::ADDR_PREDIV: n.rd_data = {8'h00, s.shd.prediv};
        pms_pkg::ADDR_STATUS: n.rd_data = st;
        default:              n.rd_data = 16'h0000;
      endcase
    end

    // Mode sequencing
    unique case (s.mode)
      pms_pkg::PMS_INIT: begin
        // Store read, data one cycle later, then next word
        if (s.nv_rd) begin
          n.nv_rd   = 1'b0;
          n.nv_pend = 1'b1;
        end else if (s.nv_pend) begin
          n.shd     = pms_cfg_wr_f(s.shd, {1'b0, s.nv_addr}, nonvolatile_store_data_i);  // R05
          n.nv_addr = s.nv_addr + 3'h1;
          n.nv_pend = 1'b0;
        end else if (s.nv_addr == pms_pkg::NV_WORDS) begin
          n.act  = s.shd;
          n.mode = pms_pkg::PMS_FREERUN;  // R11
        end else begin
          n.nv_rd = 1'b1;
        end
      end
      pms_pkg::PMS_FREERUN: begin
        if (any_v) begin
          n.mode = pms_pkg::PMS_ACQ;  // R12
          n.sel  = first_v;
        end
      end
      pms_pkg::PMS_ACQ: begin
        if (!sel_v) begin
          if (any_v) begin
            n.sel = first_v;  // R24
          end else if (s.hcnt != 5'h00) begin
            n.mode = pms_pkg::PMS_HOLD;  // R15
          end else begin
            n.mode = pms_pkg::PMS_FREERUN;
          end
        end else if (lock_detect_i) begin
          n.mode = pms_pkg::PMS_LOCKED;  // R03
        end
      end
      pms_pkg::PMS_LOCKED: begin
        if (!sel_v) begin
          if (any_v) begin
            n.mode = pms_pkg::PMS_ACQ;  // R24
            n.sel  = first_v;
          end else begin
            n.mode = pms_pkg::PMS_HOLD;  // R15
          end
        end
      end
      pms_pkg::PMS_HOLD: begin
        if (any_v) begin
          n.mode = pms_pkg::PMS_ACQ;  // R19
          n.sel  = first_v;
        end
      end
      default: begin
        n.mode = pms_pkg::PMS_FREERUN;  // R04
      end
    endcase

    // History recorded only while locked
    if (s.mode == pms_pkg::PMS_LOCKED) begin
      if (s.tick == 32'(HIST_SAMPLE_CYC - 1)) begin
        n.tick        = 32'h0;
        n.hist[s.wp]  = freq_word_i;  // R16
        n.wp          = s.wp + 4'h1;
        if (s.hcnt != 5'(pms_pkg::HIST_DEPTH)) begin
          n.hcnt = s.hcnt + 5'h01;
        end
      end else begin
        n.tick = s.tick + 32'h1;
      end
    end else begin
      n.tick = 32'h0;
    end

    // One history slot summed per cycle
    if (s.avg_busy) begin
      n.acc   = acc_new;
      n.avg_i = s.avg_i + 5'h01;
      if (s.avg_i == win - 5'h01) begin
        n.avg_busy   = 1'b0;
        n.hold_freq  = 16'(acc_new >> s.act.win_log);  // R17
        n.hold_valid = 1'b1;
      end
    end
    // Start averaging on holdover entry
    if (n.mode == pms_pkg::PMS_HOLD && s.mode != pms_pkg::PMS_HOLD) begin
      n.hold_valid = 1'b0;
      if (s.hcnt == 5'h00) begin
        n.hold_freq  = s.freq_steer;
        n.hold_valid = 1'b1;
        n.avg_busy   = 1'b0;
      end else begin
        n.avg_busy = 1'b1;
        n.avg_i    = 5'h00;
        n.acc      = 20'h0;
      end
    end
    if (n.mode != pms_pkg::PMS_HOLD) begin
      n.avg_busy   = 1'b0;
      n.hold_valid = 1'b0;
    end

    // Registered outputs
    n.out_en    = (n.mode != pms_pkg::PMS_INIT);  // R07 R13
    n.lock_loss_indicator       = (n.mode != pms_pkg::PMS_LOCKED);  // R14 R23
    n.fast_act  = (n.mode == pms_pkg::PMS_ACQ) && n.act.fast_en;  // R02
    n.active_bw = n.fast_act ? n.act.bw_fast : n.act.bw_norm;  // R01 R03
    n.load_cap  = ~n.act.ext_ref;  // R20
    unique case (n.mode)
      pms_pkg::PMS_ACQ,
      pms_pkg::PMS_LOCKED: n.freq_steer = freq_word_i;  // R13
      pms_pkg::PMS_HOLD:   n.freq_steer = n.hold_valid ? n.hold_freq : s.freq_steer;  // R18
      default:             n.freq_steer = 16'h0000;
    endcase

    // Hard reset restarts everything but the pin synchroniser
    if (hard_req) begin
      n         = pms_reset_f();  // R08
      n.s1      = rst_pin_n_i;
      n.s2      = s.s1;
      n.s3      = s.s2;
      n.pin_rst = (s.s2 == s.s3) ? ~s.s3 : s.pin_rst;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s <= pms_reset_f();
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state flops
  assign nonvolatile_store_rd_o   = s.nv_rd;
  assign nonvolatile_store_addr_o = s.nv_addr;
  assign rd_data_o                = s.rd_data;
  assign host_ready_o             = s.out_en;
  assign out_en_o                 = s.out_en;
  assign lock_loss_indicator_o    = s.lock_loss_indicator;
  assign mode_o                   = s.mode;
  assign selected_input_o         = s.sel;
  assign active_bw_o              = s.active_bw;
  assign fastlock_active_o        = s.fast_act;
  assign freq_steer_o             = s.freq_steer;
  assign ext_ref_clock_sel_o      = s.act.ext_ref;
  assign load_cap_en_o            = s.load_cap;
  assign trim_o                   = s.act.trim;
  assign prediv_o                 = s.act.prediv;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  no_clk_init_a : assert property (s.mode == pms_pkg::PMS_INIT |-> !out_en_o) // R07
    else $error("outputs enabled during initialization");
  bus_block_a : assert property (s.mode == pms_pkg::PMS_INIT |=> rd_data_o == 16'h0000) // R06
    else $error("read answered during initialization");
  init_free_a : assert property (s.mode == pms_pkg::PMS_INIT && !hard_req ##1 s.mode != pms_pkg::PMS_INIT
    |-> s.mode == pms_pkg::PMS_FREERUN) // R11
    else $error("initialization did not end in free-run");
  acq_start_a : assert property (s.mode == pms_pkg::PMS_FREERUN && any_v && !hard_req
    |=> s.mode == pms_pkg::PMS_ACQ) // R12
    else $error("valid input did not start acquisition");
  fast_bw_a : assert property (s.mode == pms_pkg::PMS_ACQ && s.act.fast_en
    |-> active_bw_o == s.act.bw_fast && fastlock_active_o) // R02
    else $error("fast bandwidth not used in acquisition");
  norm_bw_a : assert property (s.mode == pms_pkg::PMS_LOCKED |-> active_bw_o == s.act.bw_norm) // R03
    else $error("normal bandwidth not restored when locked");
  lol_pin_a : assert property (s.mode == pms_pkg::PMS_ACQ |-> lock_loss_indicator_o && st[pms_pkg::ST_LOL_BIT]) // R23
    else $error("lock loss not shown during pull-in");
  hold_entry_a : assert property (s.mode == pms_pkg::PMS_LOCKED && !any_v && !hard_req
    |=> s.mode == pms_pkg::PMS_HOLD) // R15
    else $error("holdover not entered");
  reacq_other_a : assert property (s.mode == pms_pkg::PMS_LOCKED && !sel_v && any_v && !hard_req
    |=> s.mode == pms_pkg::PMS_ACQ && input_valid_i[s.sel]) // R24
    else $error("did not reacquire on another input");
  hold_exit_a : assert property (s.mode == pms_pkg::PMS_HOLD && any_v && !hard_req
    |=> s.mode == pms_pkg::PMS_ACQ) // R19
    else $error("holdover not left for valid input");
  avg_bound_a : assert property ($rose(s.avg_busy) |-> ##[1:16] !s.avg_busy) // R17
    else $error("averaging took too long");
  hold_steer_a : assert property (s.mode == pms_pkg::PMS_HOLD && s.hold_valid ##1 s.mode == pms_pkg::PMS_HOLD
    |-> freq_steer_o == s.hold_freq) // R18
    else $error("holdover not steered to average");
  caps_off_a : assert property (ext_ref_clock_sel_o |-> !load_cap_en_o) // R20
    else $error("load capacitors on with external reference");
  hard_bit_a : assert property (wr_i && bus_ok && addr_i == pms_pkg::ADDR_CTRL && wdata_i[pms_pkg::CTRL_HARD_BIT]
    |=> s.mode == pms_pkg::PMS_INIT && !out_en_o) // R08
    else $error("hard reset bit did not restart");

endmodule : pms_pll_mode_sequencer

// ### sim/pms_store_model.sv
module pms_store_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [2:0]  addr_i,
  output logic      [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Image held in the store: fast lock on, crystal, window 4, delay 1
  logic [15:0] words [0:5] = '{16'h0001, 16'h0064, 16'h1388, 16'h0012, 16'h0000, 16'h0001};

  // Word answers one cycle after the strobe; otherwise the bus churns
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= words[addr_i];
    end else begin
      data_o <= ~data_o;
    end
  end

  initial data_o = 16'h0000;
endmodule : pms_store_model

// ### sim/pms_pll_mode_sequencer_bench.sv
module pms_pll_mode_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;         // Core clock
  logic        sys_rst_i = 1'b1;     // Synchronous reset
  logic        rst_pin_n_i = 1'b1;   // Hard reset pin
  logic [3:0]  input_valid_i = '0;   // Input qualifiers
  logic        lock_detect_i = 1'b0; // Phase lock flag
  logic [15:0] freq_word_i = 16'h1234; // Loop frequency word
  logic        nv_rd;                // Store strobe
  logic [2:0]  nv_addr;              // Store index
  logic [15:0] nv_data;              // Store word
  logic [3:0]  addr_i = '0;          // Host address
  logic [15:0] wdata_i = '0;         // Host write data
  logic        wr_i = 1'b0;          // Host write strobe
  logic        rd_i = 1'b0;          // Host read strobe
  logic [15:0] rd_data_o, active_bw_o, freq_steer_o, trim_o, rdv;
  logic        host_ready_o, out_en_o, lock_loss_indicator_o, fastlock_active_o;
  logic        ext_ref_clock_sel_o, load_cap_en_o;
  logic [2:0]  mode_o;
  logic [1:0]  selected_input_o;
  logic [7:0]  prediv_o;
  int          err_total = 0;        // Mismatches
  int          total_checks = 0;     // Comparisons
  int          cyc = 0;              // Timeout counter

  pms_pll_mode_sequencer #(.HIST_SAMPLE_CYC(8)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
    .input_valid_i(input_valid_i), .lock_detect_i(lock_detect_i), .freq_word_i(freq_word_i),
    .nonvolatile_store_rd_o(nv_rd), .nonvolatile_store_addr_o(nv_addr),
    .nonvolatile_store_data_i(nv_data), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .host_ready_o(host_ready_o), .out_en_o(out_en_o),
    .lock_loss_indicator_o(lock_loss_indicator_o), .mode_o(mode_o),
    .selected_input_o(selected_input_o), .active_bw_o(active_bw_o),
    .fastlock_active_o(fastlock_active_o), .freq_steer_o(freq_steer_o),
    .ext_ref_clock_sel_o(ext_ref_clock_sel_o), .load_cap_en_o(load_cap_en_o),
    .trim_o(trim_o), .prediv_o(prediv_o));

  pms_store_model i_store (.clk_i(clk_i), .rd_i(nv_rd), .addr_i(nv_addr), .data_o(nv_data));

  // Clock of 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Read and compare the answer in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rdv = rd_data_o;
    chk(rdv & m, exp);
    @(posedge clk_i);
    #1 chk(rd_data_o, 16'h0000);
  endtask : rd

  // Bounded wait for the host port to open
  task automatic wait_ready();
    for (int i = 0; i < 60 && host_ready_o !== 1'b1; i++) @(posedge clk_i);
    #1;
  endtask : wait_ready

  // Let mode changes land
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({15'h0, out_en_o}, 16'h0000);
    chk({15'h0, host_ready_o}, 16'h0000);
    wait_ready();
    settle();
    chk({13'h0, mode_o}, 16'h0001);
    chk(active_bw_o, 16'h0064);
    rd(pms_pkg::ADDR_BW_FAST, 16'hffff, 16'h1388);
    rd(4'hf, 16'hffff, 16'h0000);
    input_valid_i <= 4'h1;
    settle();
    chk({13'h0, mode_o}, 16'h0002);
    chk({fastlock_active_o, lock_loss_indicator_o, out_en_o}, 16'h0007);
    chk(active_bw_o, 16'h1388);
    lock_detect_i <= 1'b1;
    settle();
    chk({13'h0, mode_o}, 16'h0003);
    chk(active_bw_o, 16'h0064);
    chk({15'h0, lock_loss_indicator_o}, 16'h0000);
    rd(pms_pkg::ADDR_STATUS, 16'h000f, 16'h0003);
    repeat (80) @(posedge clk_i);
    input_valid_i <= 4'h2;
    lock_detect_i <= 1'b0;
    settle();
    chk({12'h0, selected_input_o, mode_o[1:0]}, 16'h0006);
    chk({15'h0, lock_loss_indicator_o}, 16'h0001);
    lock_detect_i <= 1'b1;
    freq_word_i   <= 16'h2000;
    repeat (60) @(posedge clk_i);
    input_valid_i <= 4'h0;
    lock_detect_i <= 1'b0;
    freq_word_i   <= 16'h5555;
    settle();
    chk({13'h0, mode_o}, 16'h0004);
    repeat (20) @(posedge clk_i);
    #1 chk(freq_steer_o, 16'h2000);
    input_valid_i <= 4'h4;
    settle();
    chk({12'h0, selected_input_o, mode_o[1:0]}, 16'h000a);
    chk(freq_steer_o, 16'h5555);
    wr(pms_pkg::ADDR_BW_NORM, 16'h0000);
    rd(pms_pkg::ADDR_BW_NORM, 16'hffff, 16'h0001);
    wr(pms_pkg::ADDR_TRIM, 16'h7530);
    rd(pms_pkg::ADDR_TRIM, 16'hffff, 16'h4e20);
    wr(pms_pkg::ADDR_PREDIV, 16'h0004);
    wr(pms_pkg::ADDR_CTRL, 16'h0006);
    settle();
    chk({14'h0, ext_ref_clock_sel_o, load_cap_en_o}, 16'h0002);
    chk({8'h0, prediv_o}, 16'h0004);
    chk(trim_o, 16'h4e20);
    rd(pms_pkg::ADDR_CTRL, 16'hffff, 16'h0002);
    wr(pms_pkg::ADDR_CTRL, 16'h0008);
    #1 chk({15'h0, host_ready_o}, 16'h0000);
    wait_ready();
    chk({14'h0, ext_ref_clock_sel_o, load_cap_en_o}, 16'h0001);
    wr(pms_pkg::ADDR_PREDIV, 16'h0009);
    rst_pin_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1 chk({15'h0, out_en_o}, 16'h0000);
    rst_pin_n_i <= 1'b1;
    wait_ready();
    rd(pms_pkg::ADDR_PREDIV, 16'hffff, 16'h0001);
    finish_test();
  end
endmodule : pms_pll_mode_sequencer_bench
